//--- testbench/mac_model.sv
module mac_model (
	input  wire logic       clock_in,
	input  wire logic       sys_rst_in,
	input  wire logic       start_in,
	input  wire logic [3:0] len_in,
	output logic            tx_en_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left;
	// enable moves only right after the rising edge
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) left <= 4'h0;
		else if (left != 4'h0) left <= left - 4'h1;
		else if (start_in) left <= len_in;
	end
	assign tx_en_out = left != 4'h0;
endmodule : mac_model

//--- testbench/phy_status_pins_monitor.sv
module phy_status_pins_monitor #(
	parameter int HARD_RESET_CYCLES = 8
) (
	input wire logic                   clock_in,
	input wire logic                   sys_rst_in,
	input wire logic                   hard_reset_n_in,
	input wire phy_pins_pkg::axi_req_t axi_req_in,
	input wire phy_pins_pkg::axi_rsp_t axi_rsp_out,
	input wire logic                   rmii_mode_in,
	input wire logic                   full_duplex_in,
	input wire logic                   tx_active_in,
	input wire logic                   rx_active_in,
	input wire logic                   collision_pin_in,
	input wire logic                   collision_pin_out,
	input wire logic                   collision_pin_oe_out,
	input wire logic                   carrier_pin_out,
	input wire logic                   carrier_pin_oe_out,
	input wire logic                   link_activity_led_oe_out,
	input wire logic                   ref_clock_oe_out,
	input wire logic                   tx_error_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0]  ctrl_sh;
	logic [6:0]  w_d;
	logic [7:0]  aw_a;
	logic        w_s;
	logic        known;
	logic [15:0] low_cnt;
	wire aw_hs   = axi_req_in.awvalid && axi_rsp_out.awready;
	wire w_hs    = axi_req_in.wvalid && axi_rsp_out.wready;
	wire b_hs    = axi_rsp_out.bvalid && axi_req_in.bready;
	wire ctrl_wr = b_hs && aw_a == phy_pins_pkg::CTRL_OFFSET && w_s;
	// shadow trusted only from a finished write until any reset or new write
	wire mii     = known && !rmii_mode_in && !ctrl_sh[4];

	always_ff @(posedge clock_in) begin
		if (aw_hs) aw_a <= axi_req_in.awaddr;
		if (w_hs) w_d <= axi_req_in.wdata[6:0];
		if (w_hs) w_s <= axi_req_in.wstrb[0];
		if (ctrl_wr) ctrl_sh <= w_d;
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in || !hard_reset_n_in || aw_hs) known <= 1'b0;
		else if (ctrl_wr) known <= 1'b1;
		if (sys_rst_in || hard_reset_n_in) low_cnt <= '0;
		else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h1;
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	property p_col_full;
		mii && ctrl_sh[1:0] == 2'h0 && full_duplex_in |=> !collision_pin_out;
	endproperty
	a_col_full: assert property (p_col_full)
		else $error("collision seen in full duplex");
	property p_col_half;
		mii && ctrl_sh[1:0] == 2'h0 && !full_duplex_in |=>
			collision_pin_out == $past(tx_active_in && rx_active_in);
	endproperty
	a_col_half: assert property (p_col_half)
		else $error("collision level wrong in half duplex");
	property p_crs;
		mii && !ctrl_sh[2] |=>
			carrier_pin_out == $past(tx_active_in || rx_active_in);
	endproperty
	a_crs: assert property (p_crs)
		else $error("carrier level wrong");
	property p_tx_err;
		known && ctrl_sh[1:0] == 2'h2 |=>
			!collision_pin_oe_out && tx_error_out == $past(collision_pin_in);
	endproperty
	a_tx_err: assert property (p_tx_err)
		else $error("transmit error input not followed");
	property p_quiet;
		disable iff (1'b0) sys_rst_in |=> !collision_pin_oe_out &&
			!carrier_pin_oe_out && !link_activity_led_oe_out;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("pin driven during reset");
	property p_hard_full;
		low_cnt >= 16'(HARD_RESET_CYCLES + 2) |->
			!carrier_pin_oe_out && !axi_rsp_out.arready;
	endproperty
	a_hard_full: assert property (p_hard_full)
		else $error("long hard reset had no effect");
	property p_ref_hold;
		!hard_reset_n_in && ref_clock_oe_out |=> ref_clock_oe_out;
	endproperty
	a_ref_hold: assert property (p_ref_hold)
		else $error("reference pin released by hard reset");
	property p_b_lat;
		aw_hs && w_hs |-> ##2 axi_rsp_out.bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat)
		else $error("write response late");
	property p_r_lat;
		axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat)
		else $error("read data late");

	c_col: cover property (mii && collision_pin_out);
	c_txerr: cover property (known && ctrl_sh[1:0] == 2'h2 && tx_error_out);
	c_hard: cover property (low_cnt == 16'(HARD_RESET_CYCLES + 2));
endmodule : phy_status_pins_monitor

bind phy_status_pins phy_status_pins_monitor #(
	.HARD_RESET_CYCLES(HARD_RESET_CYCLES)
) i_phy_status_pins_monitor (.*);

//--- testbench/tb_phy_status_pins.sv
module tb_phy_status_pins;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, sys_rst_in, hard_reset_n_in, rmii_mode_in;
	logic full_duplex_in, link_up_in, link_100_in, rx_active_in;
	logic tx_active_in, pinout_mode_strap_in, tx_error_out;
	logic link_activity_led_out, link_activity_led_oe_out, ref_clock_out;
	logic ref_clock_oe_out, collision_pin_out, collision_pin_oe_out;
	logic carrier_pin_out, carrier_pin_oe_out, common_pinout_mode_out;
	logic led_pull, col_ext, ref_pull, mac_go, col_exp, crs_exp;
	logic [3:0]  mac_len;
	logic [31:0] rnd, d;
	logic [1:0]  r;
	int          error_cnt, n_compared, cnt;
	phy_pins_pkg::axi_req_t axi_req_in;
	phy_pins_pkg::axi_rsp_t axi_rsp_out;
	wire link_activity_led_in = link_activity_led_oe_out ?
		link_activity_led_out : led_pull;
	wire ref_clock_pin_in = ref_clock_oe_out ? ref_clock_out : ref_pull;
	wire collision_pin_in = collision_pin_oe_out ? collision_pin_out : col_ext;
	wire carrier_pin_in   = carrier_pin_oe_out ? carrier_pin_out : 1'b0;

	phy_status_pins #(
		.HARD_RESET_CYCLES(8),
		.BLINK_HALF_CYCLES(4),
		.REF_HALF_CYCLES(5)
	) i_phy_status_pins (.*);

	mac_model i_mac_model (
		.clock_in (clock_in),
		.sys_rst_in(sys_rst_in),
		.start_in (mac_go),
		.len_in   (mac_len),
		.tx_en_out(tx_active_in)
	);

	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	// ------
	// helpers
	// ------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// pull high at strap time means active low
	function automatic logic led_lvl(input logic on, input logic pull);
		return on ^ pull;
	endfunction : led_lvl

	function automatic logic col_f(input logic fdx, tx, rx);
		return !fdx && tx && rx;
	endfunction : col_f

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_in);
		axi_req_in.awvalid <= 1'b1;
		axi_req_in.awaddr  <= a;
		axi_req_in.wvalid  <= 1'b1;
		axi_req_in.wdata   <= v;
		axi_req_in.wstrb   <= 4'hf;
		axi_req_in.bready  <= 1'b1;
		forever begin
			@(posedge clock_in);
			if (axi_rsp_out.awready) axi_req_in.awvalid <= 1'b0;
			if (axi_rsp_out.wready) axi_req_in.wvalid <= 1'b0;
			if (axi_rsp_out.bvalid) break;
		end
		r = axi_rsp_out.bresp;
		axi_req_in.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clock_in);
		axi_req_in.arvalid <= 1'b1;
		axi_req_in.araddr  <= a;
		axi_req_in.rready  <= 1'b1;
		forever begin
			@(posedge clock_in);
			if (axi_rsp_out.arready) axi_req_in.arvalid <= 1'b0;
			if (axi_rsp_out.rvalid) break;
		end
		{d, r} = {axi_rsp_out.rdata, axi_rsp_out.rresp};
		axi_req_in.rready <= 1'b0;
	endtask : rd

	task automatic toggles(input bit led, input int n);
		logic p;
		logic v;
		cnt = 0;
		p = led ? link_activity_led_out : ref_clock_out;
		repeat (n) begin
			@(posedge clock_in);
			v = led ? link_activity_led_out : ref_clock_out;
			if (v !== p) cnt++;
			p = v;
		end
	endtask : toggles

	task automatic rst();
		sys_rst_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask : rst

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask : tick

	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		$display("wrong value at %0t ns: watchdog expired", $time);
		summarize();
	end

	// ------
	// sequence
	// ------
	initial begin
		{sys_rst_in, hard_reset_n_in, led_pull, ref_pull} = 4'hf;
		{rmii_mode_in, full_duplex_in, link_up_in, link_100_in} = 4'h0;
		{rx_active_in, pinout_mode_strap_in, col_ext, mac_go} = 4'h0;
		{col_exp, crs_exp, mac_len, axi_req_in} = '0;
		{error_cnt, n_compared, rnd} = {32'h0, 32'h0, 32'hbb6c8699};
		@(posedge clock_in);
		rst();
		rd(8'h04);
		chk(d[3:0], 4'h1);
		chk(common_pinout_mode_out, 1'b1);
		rd(8'h08);
		chk(d, 32'h0);
		chk(r, 2'h2);
		wr(8'h08, 32'h7f);
		chk(r, 2'h2);
		rd(8'h00);
		chk(d[6:0], 7'h00);
		toggles(0, 100);
		chk(cnt, 20);
		$display("straps and clock done");
		wr(8'h00, 32'h0);
		chk(r, 2'h0);
		repeat (300) begin
			@(posedge clock_in);
			chk(collision_pin_out, col_exp);
			chk(carrier_pin_out, crs_exp);
			col_exp = col_f(full_duplex_in, tx_active_in, rx_active_in);
			crs_exp = tx_active_in || rx_active_in;
			rnd = lfsr(rnd);
			full_duplex_in <= rnd[0] & rnd[1];
			rx_active_in   <= rnd[2];
			mac_go         <= rnd[3];
			mac_len        <= rnd[7:4];
		end
		@(posedge clock_in);
		{full_duplex_in, rx_active_in, mac_go} <= 3'h0;
		link_up_in <= 1'b1;
		tick(20);
		chk(link_activity_led_out, led_lvl(1'b1, led_pull));
		rx_active_in <= 1'b1;
		toggles(1, 40);
		chk(cnt >= 9, 1'b1);
		{rx_active_in, link_up_in} <= 2'h0;
		tick(3);
		chk(link_activity_led_out, led_lvl(1'b0, led_pull));
		$display("collision, carrier and link done");
		wr(8'h00, 32'h8);
		link_up_in <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			link_100_in <= i[0];
			tick(3);
			chk(ref_clock_out, led_lvl(i[0], ref_pull));
		end
		wr(8'h00, 32'h2);
		col_ext <= 1'b1;
		tick(3);
		chk({collision_pin_oe_out, tx_error_out}, 2'b01);
		col_ext <= 1'b0;
		wr(8'h00, 32'h63);
		tick(2);
		chk({collision_pin_oe_out, collision_pin_out}, 2'b11);
		full_duplex_in <= 1'b1;
		wr(8'h00, 32'h1);
		tick(2);
		chk(collision_pin_out, 1'b1);
		wr(8'h00, 32'h10);
		tick(3);
		toggles(0, 20);
		chk(cnt, 0);
		wr(8'h00, 32'h0);
		tick(2);
		toggles(0, 20);
		chk(cnt, 4);
		$display("pin functions done");
		wr(8'h00, 32'h4);
		{pinout_mode_strap_in, led_pull, ref_pull} <= 3'b100;
		hard_reset_n_in <= 1'b0;
		tick(5);
		hard_reset_n_in <= 1'b1;
		tick(3);
		rd(8'h00);
		chk(d[6:0], 7'h04);
		// held well past the minimum low time
		hard_reset_n_in <= 1'b0;
		toggles(0, 20);
		chk(cnt, 4);
		hard_reset_n_in <= 1'b1;
		tick(3);
		rd(8'h00);
		chk(d[6:0], 7'h00);
		rd(8'h04);
		chk(d[3:0], 4'h8);
		rmii_mode_in <= 1'b1;
		rst();
		rd(8'h00);
		chk(d[6:0], 7'h05);
		rd(8'h04);
		chk(d[2], 1'b1);
		$display("resets done");
		summarize();
	end
endmodule : tb_phy_status_pins

//--- verilog/phy_pins_pkg.sv
package phy_pins_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLOCK_PERIOD_PS    = 4000;
	localparam int HARD_RESET_MIN_NS  = 25000;
	localparam int HARD_RESET_CYCLES  =
		(HARD_RESET_MIN_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int BLINK_HALF_MS      = 50;
	localparam int BLINK_HALF_CYCLES  =
		(BLINK_HALF_MS * 1000000 / CLOCK_PERIOD_PS) * 1000;
	localparam int REF_CLOCK_KHZ      = 25000;
	// half period of the reference clock, rounded down
	localparam int REF_HALF_CYCLES    =
		1000000000 / (REF_CLOCK_KHZ * 2) / CLOCK_PERIOD_PS;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h04;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// collision pin function select
	typedef enum logic [1:0] {
		COL_FUNC_COLLISION = 2'h0,
		COL_FUNC_AUX_LED   = 2'h1,
		COL_FUNC_TX_ERROR  = 2'h2,
		COL_FUNC_GPIO      = 2'h3
	} col_func_t;

	typedef enum logic [2:0] {
		SEL_NONE   = 3'h1,
		SEL_CTRL   = 3'h2,
		SEL_STATUS = 3'h4
	} reg_sel_t;

	// control register, bits 6:0 of the word
	typedef struct packed {
		logic      gpio_drive;
		logic      gpio_value;
		logic      deep_power_down;
		logic      speed_led_en;
		logic      crs_as_led;
		col_func_t col_func;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{
		gpio_drive: 1'b0, gpio_value: 1'b0, deep_power_down: 1'b0,
		speed_led_en: 1'b0, crs_as_led: 1'b0,
		col_func: COL_FUNC_COLLISION};

	typedef struct packed {
		logic               awvalid;
		logic [ADDR_W-1:0]  awaddr;
		logic               wvalid;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               bready;
		logic               arvalid;
		logic [ADDR_W-1:0]  araddr;
		logic               rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;

endpackage : phy_pins_pkg

//--- verilog/phy_status_pins.sv
// Operation
// - MII full duplex holds collision output low whenever the collision function is selected.
// - MII half duplex: collision only while transmit and receive both busy.
// - collision pin selectable as aux LED, transmit error or GPIO; RMII: LED.
// - MII carrier sense high while receive or transmit medium is busy.
// - carrier pin selectable as third aux LED; RMII defaults to that LED.
// - link/activity LED on with good link, blinks during transmit or receive.
// - each LED active level comes from its sensed strap pull.
// - after power-on with its strap pulled high the reference pin outputs a 25 MHz clock.
// - reference clock survives hard reset; only power-on reset or deep power down stops it.
// - speed LED on for 100 M link, off for 10 M or no link.
// - speed LED strap latched at power-up only, not on pin reset.
// - hard reset held low 25 us at least then causes full reset.
// - hard reset re-samples all straps except the speed LED strap and restores register defaults.
// - grounded mode strap selects common pinout, open or high extended.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
module phy_status_pins #(
	parameter int HARD_RESET_CYCLES = phy_pins_pkg::HARD_RESET_CYCLES,
	parameter int BLINK_HALF_CYCLES = phy_pins_pkg::BLINK_HALF_CYCLES,
	parameter int REF_HALF_CYCLES   = phy_pins_pkg::REF_HALF_CYCLES
) (
	input  wire logic                   clock_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   hard_reset_n_in,
	input  wire phy_pins_pkg::axi_req_t axi_req_in,
	output phy_pins_pkg::axi_rsp_t      axi_rsp_out,
	input  wire logic                   rmii_mode_in,
	input  wire logic                   full_duplex_in,
	input  wire logic                   link_up_in,
	input  wire logic                   link_100_in,
	input  wire logic                   tx_active_in,
	input  wire logic                   rx_active_in,
	input  wire logic                   pinout_mode_strap_in,
	input  wire logic                   link_activity_led_in,
	output logic                        link_activity_led_out,
	output logic                        link_activity_led_oe_out,
	input  wire logic                   ref_clock_pin_in,
	output logic                        ref_clock_out,
	output logic                        ref_clock_oe_out,
	input  wire logic                   collision_pin_in,
	output logic                        collision_pin_out,
	output logic                        collision_pin_oe_out,
	input  wire logic                   carrier_pin_in,
	output logic                        carrier_pin_out,
	output logic                        carrier_pin_oe_out,
	output logic                        tx_error_out,
	output logic                        common_pinout_mode_out
);

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	generate
		if (HARD_RESET_CYCLES < 1 || BLINK_HALF_CYCLES < 1 ||
		    REF_HALF_CYCLES < 1) begin : g_bad_param
			$error("phy_status_pins: counts must be at least one");
		end
	endgenerate

	localparam int HR_W = $clog2(HARD_RESET_CYCLES + 1);
	localparam int BL_W = $clog2(BLINK_HALF_CYCLES + 1);
	localparam int RF_W = $clog2(REF_HALF_CYCLES + 1);
	localparam logic [HR_W-1:0] HR_LAST = HR_W'(HARD_RESET_CYCLES);
	localparam logic [BL_W-1:0] BL_LAST = BL_W'(BLINK_HALF_CYCLES - 1);
	localparam logic [RF_W-1:0] RF_LAST = RF_W'(REF_HALF_CYCLES - 1);

	function automatic phy_pins_pkg::reg_sel_t decode_reg(
		input logic [phy_pins_pkg::ADDR_W-1:0] addr
	);
		if (addr == phy_pins_pkg::CTRL_OFFSET)
			return phy_pins_pkg::SEL_CTRL;
		else if (addr == phy_pins_pkg::STATUS_OFFSET)
			return phy_pins_pkg::SEL_STATUS;
		else
			return phy_pins_pkg::SEL_NONE;
	endfunction : decode_reg

	// ------------------------------------------------------------------
	// hard reset pin
	// ------------------------------------------------------------------
	logic [HR_W-1:0] hr_count;
	wire             hr_done  = (hr_count == HR_LAST);
	// shorter pulses are ignored as glitches
	wire             in_hard_reset = hr_done & ~hard_reset_n_in;
	wire             dev_rst  = sys_rst_in | in_hard_reset;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in || hard_reset_n_in)
			hr_count <= '0;
		else if (!hr_done)
			hr_count <= hr_count + HR_W'(1);
	end

	// ------------------------------------------------------------------
	// straps
	// ------------------------------------------------------------------
	// pins float as inputs while pending; sampled one cycle after release
	logic strap_pending;
	logic por_pending;
	logic speed_strap;
	logic pinout_ext;
	logic link_led_pol;
	logic speed_led_pol;
	logic col_led_pol;
	logic crs_led_pol;

	wire strap_take = strap_pending & ~dev_rst;
	wire por_take   = por_pending & ~sys_rst_in;

	always_ff @(posedge clock_in) begin
		if (dev_rst)
			strap_pending <= 1'b1;
		else
			strap_pending <= 1'b0;
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			por_pending   <= 1'b1;
			speed_strap   <= 1'b0;
			speed_led_pol <= 1'b0;
		end else if (por_take) begin
			por_pending   <= 1'b0;
			// pulled low selects the speed LED, pulled high the clock
			speed_strap   <= ~ref_clock_pin_in;
			speed_led_pol <= ~ref_clock_pin_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pinout_ext   <= 1'b1;
			link_led_pol <= 1'b0;
			col_led_pol  <= 1'b0;
			crs_led_pol  <= 1'b0;
		end else if (strap_take) begin
			pinout_ext   <= pinout_mode_strap_in;
			// a pull-down means the LED lights when driven high
			link_led_pol <= ~link_activity_led_in;
			col_led_pol  <= ~collision_pin_in;
			crs_led_pol  <= ~carrier_pin_in;
		end
	end

	// ------------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------------
	phy_pins_pkg::ctrl_t ctrl;
	phy_pins_pkg::ctrl_t ctrl_default;
	logic                aw_have;
	logic                w_have;
	logic [phy_pins_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;

	assign ctrl_default = '{
		gpio_drive: 1'b0, gpio_value: 1'b0, deep_power_down: 1'b0,
		speed_led_en: 1'b0,
		crs_as_led: rmii_mode_in,
		col_func: rmii_mode_in ? phy_pins_pkg::COL_FUNC_AUX_LED
		                       : phy_pins_pkg::COL_FUNC_COLLISION};

	wire aw_fire  = axi_req_in.awvalid & axi_rsp_out.awready;
	wire w_fire   = axi_req_in.wvalid & axi_rsp_out.wready;
	wire b_fire   = axi_req_in.bready & axi_rsp_out.bvalid;
	wire ar_fire  = axi_req_in.arvalid & axi_rsp_out.arready;
	wire r_fire   = axi_req_in.rready & axi_rsp_out.rvalid;
	wire do_write = aw_have & w_have & ~axi_rsp_out.bvalid;

	wire phy_pins_pkg::reg_sel_t wsel = decode_reg(aw_addr);
	wire phy_pins_pkg::reg_sel_t rsel = decode_reg(axi_req_in.araddr);
	wire ctrl_wr = do_write & (wsel == phy_pins_pkg::SEL_CTRL) & w_strb[0];

	wire next_aw_have = (aw_have | aw_fire) & ~do_write;
	wire next_w_have  = (w_have | w_fire) & ~do_write;
	wire next_bvalid  = do_write | (axi_rsp_out.bvalid & ~b_fire);
	wire next_rvalid  = ar_fire | (axi_rsp_out.rvalid & ~r_fire);

	logic [31:0] status_word;
	assign status_word = {23'h0, tx_error_out, collision_pin_in,
		crs_led_pol, col_led_pol, speed_led_pol, link_led_pol,
		speed_strap, rmii_mode_in, ~pinout_ext};

	wire [31:0] read_word =
		(rsel == phy_pins_pkg::SEL_CTRL)   ? {25'h0, ctrl} :
		(rsel == phy_pins_pkg::SEL_STATUS) ? status_word : 32'h0;

	always_ff @(posedge clock_in) begin
		if (dev_rst)
			ctrl <= phy_pins_pkg::CTRL_RESET;
		else if (strap_take)
			ctrl <= ctrl_default;
		else if (ctrl_wr)
			ctrl <= phy_pins_pkg::ctrl_t'(w_data[6:0]);
	end

	always_ff @(posedge clock_in) begin
		if (dev_rst) begin
			aw_have     <= 1'b0;
			w_have      <= 1'b0;
			aw_addr     <= '0;
			w_data      <= 32'h0;
			w_strb      <= 4'h0;
			axi_rsp_out <= '0;
		end else begin
			aw_have <= next_aw_have;
			w_have  <= next_w_have;
			if (aw_fire)
				aw_addr <= axi_req_in.awaddr;
			if (w_fire) begin
				w_data <= axi_req_in.wdata;
				w_strb <= axi_req_in.wstrb;
			end
			axi_rsp_out.awready <= ~next_aw_have & ~next_bvalid;
			axi_rsp_out.wready  <= ~next_w_have & ~next_bvalid;
			axi_rsp_out.bvalid  <= next_bvalid;
			if (do_write)
				axi_rsp_out.bresp <= (wsel == phy_pins_pkg::SEL_NONE)
					? phy_pins_pkg::RESP_SLVERR : phy_pins_pkg::RESP_OKAY;
			axi_rsp_out.arready <= ~next_rvalid;
			axi_rsp_out.rvalid  <= next_rvalid;
			if (ar_fire) begin
				axi_rsp_out.rdata <= read_word;
				axi_rsp_out.rresp <= (rsel == phy_pins_pkg::SEL_NONE)
					? phy_pins_pkg::RESP_SLVERR : phy_pins_pkg::RESP_OKAY;
			end
		end
	end

	// ------------------------------------------------------------------
	// activity blink
	// ------------------------------------------------------------------
	logic [BL_W-1:0] blink_count;
	logic            blink_phase;
	wire             activity = tx_active_in | rx_active_in;

	always_ff @(posedge clock_in) begin
		if (dev_rst || !activity) begin
			blink_count <= '0;
			blink_phase <= 1'b0;
		end else if (blink_count == BL_LAST) begin
			blink_count <= '0;
			blink_phase <= ~blink_phase;
		end else begin
			blink_count <= blink_count + BL_W'(1);
		end
	end

	// ------------------------------------------------------------------
	// reference clock divider
	// ------------------------------------------------------------------
	// only power-on reset or deep power down clears it, so a hard reset never glitches the clock
	logic [RF_W-1:0] ref_count;
	logic            ref_phase;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in || ctrl.deep_power_down) begin
			ref_count <= '0;
			ref_phase <= 1'b0;
		end else if (ref_count == RF_LAST) begin
			ref_count <= '0;
			ref_phase <= ~ref_phase;
		end else begin
			ref_count <= ref_count + RF_W'(1);
		end
	end

	// ------------------------------------------------------------------
	// pin functions
	// ------------------------------------------------------------------
	wire link_on   = link_up_in & ~(activity & blink_phase);
	wire speed_on  = link_up_in & link_100_in;
	wire speed_sel = speed_strap | ctrl.speed_led_en;
	wire col_mii   = ~full_duplex_in &
	                 tx_active_in & rx_active_in;
	wire crs_mii   = activity;
	wire aux2_on   = link_up_in & full_duplex_in;
	wire aux3_on   = activity;

	logic next_col_out;
	logic next_col_oe;
	always_comb begin
		next_col_out = 1'b0;
		next_col_oe  = 1'b1;
		unique case (ctrl.col_func)
			phy_pins_pkg::COL_FUNC_COLLISION: next_col_out = col_mii;
			phy_pins_pkg::COL_FUNC_AUX_LED:
				next_col_out = aux2_on ~^ col_led_pol;
			phy_pins_pkg::COL_FUNC_TX_ERROR: next_col_oe = 1'b0;
			phy_pins_pkg::COL_FUNC_GPIO: begin
				next_col_out = ctrl.gpio_value;
				next_col_oe  = ctrl.gpio_drive;
			end
		endcase
	end

	wire next_crs_out = ctrl.crs_as_led ? (aux3_on ~^ crs_led_pol)
	                                    : crs_mii;
	wire next_ref_out = speed_sel ? (speed_on ~^ speed_led_pol)
	                              : ref_phase;

	always_ff @(posedge clock_in) begin
		if (dev_rst || strap_pending) begin
			link_activity_led_out    <= 1'b0;
			link_activity_led_oe_out <= 1'b0;
			collision_pin_out        <= 1'b0;
			collision_pin_oe_out     <= 1'b0;
			carrier_pin_out          <= 1'b0;
			carrier_pin_oe_out       <= 1'b0;
			tx_error_out             <= 1'b0;
		end else begin
			link_activity_led_out    <= link_on ~^ link_led_pol;
			link_activity_led_oe_out <= 1'b1;
			collision_pin_out        <= next_col_out;
			collision_pin_oe_out     <= next_col_oe;
			carrier_pin_out          <= next_crs_out;
			carrier_pin_oe_out       <= 1'b1;
			tx_error_out             <= (ctrl.col_func ==
				phy_pins_pkg::COL_FUNC_TX_ERROR) & collision_pin_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in || por_pending) begin
			ref_clock_out    <= 1'b0;
			ref_clock_oe_out <= 1'b0;
		end else begin
			ref_clock_out    <= next_ref_out;
			ref_clock_oe_out <= 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in)
			common_pinout_mode_out <= 1'b0;
		else
			common_pinout_mode_out <= ~pinout_ext;
	end

endmodule : phy_status_pins
